//--- core/ccg_pkg.sv
// Purpose: shared constants and carrier types of the crc generator
// Assumes: one 20 MHz peripheral clock, byte-wide register port
// Notes:   offsets are the byte addresses of the register port
package ccg_pkg;
  // ==========================================================
  // register offsets
  localparam logic [2:0] ADDR_CONTROL = 3'h0;
  localparam logic [2:0] ADDR_STATUS  = 3'h2;
  localparam logic [2:0] ADDR_BYTE_IN = 3'h3;
  localparam logic [2:0] ADDR_CS0     = 3'h4;
  localparam logic [2:0] ADDR_CS1     = 3'h5;
  localparam logic [2:0] ADDR_CS2     = 3'h6;
  localparam logic [2:0] ADDR_CS3     = 3'h7;
  // ==========================================================
  // field positions
  localparam int CTL_RST_HI = 7;
  localparam int CTL_RST_LO = 6;
  localparam int CTL_WIDE   = 5;
  localparam int STS_ZERO   = 1;
  localparam int STS_BUSY   = 0;
  // ==========================================================
  // source codes
  localparam logic [3:0] SRC_OFF   = 4'h0;
  localparam logic [3:0] SRC_IO    = 4'h1;
  localparam logic [3:0] SRC_FLASH = 4'h2;
  localparam logic [1:0] SRC_DMA   = 2'h1;
  // ==========================================================
  // polynomials and checksum values
  localparam logic [15:0] POLY_NARROW = 16'h1021;
  localparam logic [31:0] POLY_WIDE   = 32'h04C11DB7;
  localparam logic [31:0] CS_ONES     = 32'hFFFFFFFF;
  localparam logic [31:0] CS_ZEROS    = 32'h00000000;
  localparam logic [7:0]  BYTE_ZERO   = 8'h00;
  // ==========================================================
  // carriers
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ccg_req_t;
  typedef struct packed {
    logic [3:0]      valid;
    logic [3:0]      done;
    logic [3:0][7:0] data;
  } ccg_dma_t;
  typedef struct packed {
    logic       valid;
    logic       done;
    logic [7:0] data;
  } ccg_flash_t;
  typedef struct packed {
    logic [3:0]  src;
    logic        wide;
    logic        busy;
    logic        zero;
    logic        rst_pend;
    logic        rst_ones;
    logic [31:0] raw;
    logic [7:0]  rdata;
  } ccg_state_t;
endpackage

//--- core/ccg_top.sv
// Purpose: byte-wide crc generator with selectable input source
// Assumes: inputs synchronous to I_CLOCK, reads answer one cycle late
// Notes:   all state is one struct, filled combinationally
//
// Operation
// - compute crc with 0x1021 or 0x04C11DB7 per polynomial select
// - wide and idle: checksum reads bit-reversed and inverted
// - narrow, or busy with io or dma source: checksum reads raw internal value
// - narrow by default; flash source forces wide polynomial
// - one byte per cycle, checksum updated one clock after write
// - reset field: 10 clears, 11 presets ones, reads zero
// - soft reset takes effect one cycle after reset high bit write
// - polynomial select bit ignored while busy
// - source codes: off, io, flash, dma channels zero to three
// - selected source locked until completion or soft reset
// - zero flag set on zero checksum at completion, cleared on select
// - wide residue 0x2144df1c, or zero with complemented checksum
// - busy while source in use; io completion by writing one
// - dma done or abort, or flash finish, clears busy
// - selected dma channel bytes are all folded in
// - checksum registers writable only with source disabled
// - flash source busy: checksum reads return zero
// - checksum bits 7 to 0 at offset 0x04
// - upper checksum bytes at offsets 0x05, 0x06 and 0x07
module ccg_top
(
  input  wire logic                I_CLOCK,
  input  wire logic                I_RST_N,
  input  wire ccg_pkg::ccg_req_t   I_REQ,
  input  wire ccg_pkg::ccg_dma_t   I_DMA,
  input  wire ccg_pkg::ccg_flash_t I_FLASH,
  output logic [7:0]               O_RDATA,
  output logic                     O_BUSY,
  output logic                     O_ZERO
);

  // ==========================================================
  // crc helpers
  // polynomial fold
  function automatic logic [31:0] crc_fold
  (
    input logic [31:0] crc,
    input logic [7:0]  din,
    input logic        wide
  );
    logic [31:0] c;
    logic        fb;
    c  = crc;
    fb = 1'b0;
    if (wide)
    begin
      // reflected input order gives the standard residue
      for (int i = 0; i < 8; i++)
      begin
        fb = c[31] ^ din[i];
        c  = {c[30:0], 1'b0} ^ (fb ? ccg_pkg::POLY_WIDE : ccg_pkg::CS_ZEROS);
      end
    end
    else
    begin
      for (int i = 7; i >= 0; i--)
      begin
        fb       = c[15] ^ din[i];
        c[15:0]  = {c[14:0], 1'b0} ^ (fb ? ccg_pkg::POLY_NARROW : 16'h0000);
      end
    end
    return c;
  endfunction

  function automatic logic [31:0] rev32(input logic [31:0] v);
    logic [31:0] r;
    r = ccg_pkg::CS_ZEROS;
    for (int i = 0; i < 32; i++)
    begin
      r[i] = v[31 - i];
    end
    return r;
  endfunction

  // ==========================================================
  // state
  ccg_pkg::ccg_state_t st;
  ccg_pkg::ccg_state_t next_st;

  logic        eff_wide;
  logic        src_dma;
  logic [1:0]  dma_ch;
  logic        hit_ctl;
  logic        hit_sts;
  logic        hit_byte;
  logic        hit_cs;
  logic [1:0]  cs_idx;
  logic        in_ok;
  logic [7:0]  in_byte;
  logic        done;
  logic        src_valid;
  logic [31:0] view;
  logic [7:0]  rd_mux;
  logic [3:0]  new_src;

  assign eff_wide  = st.wide | (st.src == ccg_pkg::SRC_FLASH);
  // dma codes 0100 to 0111 carry the channel in the low bits
  assign src_dma   = (st.src[3:2] == ccg_pkg::SRC_DMA);
  assign dma_ch    = st.src[1:0];
  assign hit_ctl   = I_REQ.wr & (I_REQ.addr == ccg_pkg::ADDR_CONTROL);
  assign hit_sts   = I_REQ.wr & (I_REQ.addr == ccg_pkg::ADDR_STATUS);
  assign hit_byte  = I_REQ.wr & (I_REQ.addr == ccg_pkg::ADDR_BYTE_IN);
  assign hit_cs    = I_REQ.wr & I_REQ.addr[2];
  assign cs_idx    = I_REQ.addr[1:0];
  assign new_src   = I_REQ.wdata[3:0];
  assign src_valid = (new_src == ccg_pkg::SRC_IO)
                   | (new_src == ccg_pkg::SRC_FLASH)
                   | (new_src[3:2] == ccg_pkg::SRC_DMA);

  // ==========================================================
  // input selection and completion
  always_comb
  begin
    in_ok   = 1'b0;
    in_byte = ccg_pkg::BYTE_ZERO;
    done    = 1'b0;
    if (st.busy)
    begin
      if (st.src == ccg_pkg::SRC_IO)
      begin
        in_ok   = hit_byte;
        in_byte = I_REQ.wdata;
        // software ends an io run by writing one to busy
        done    = hit_sts & I_REQ.wdata[ccg_pkg::STS_BUSY];
      end
      else if (st.src == ccg_pkg::SRC_FLASH)
      begin
        in_ok   = I_FLASH.valid;
        in_byte = I_FLASH.data;
        done    = I_FLASH.done;
      end
      else if (src_dma)
      begin
        // every byte through the selected channel
        in_ok   = I_DMA.valid[dma_ch];
        in_byte = I_DMA.data[dma_ch];
        // channel completion or abort ends the run
        done    = I_DMA.done[dma_ch];
      end
    end
  end

  // ==========================================================
  // read view of the checksum
  always_comb
  begin
    // wide and idle reads reversed and inverted
    view = (eff_wide & ~st.busy) ? ~rev32(st.raw) : st.raw;
    if ((st.src == ccg_pkg::SRC_FLASH) & st.busy)
    begin
      view = ccg_pkg::CS_ZEROS;
    end
    case (I_REQ.addr)
      ccg_pkg::ADDR_CONTROL:
        rd_mux = {2'b00, st.wide, 1'b0, st.src};
      ccg_pkg::ADDR_STATUS:
        rd_mux = {6'h00, st.zero, st.busy};
      ccg_pkg::ADDR_CS0:
        rd_mux = view[7:0];
      ccg_pkg::ADDR_CS1:
        rd_mux = view[15:8];
      ccg_pkg::ADDR_CS2:
        rd_mux = view[23:16];
      ccg_pkg::ADDR_CS3:
        rd_mux = view[31:24];
      default:
        rd_mux = ccg_pkg::BYTE_ZERO;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    next_st = st;
    if (I_REQ.rd)
    begin
      next_st.rdata = rd_mux;
    end
    if (st.rst_pend)
    begin
      // clear or preset, and release the source lock
      next_st.raw      = st.rst_ones ? ccg_pkg::CS_ONES : ccg_pkg::CS_ZEROS;
      next_st.src      = ccg_pkg::SRC_OFF;
      next_st.busy     = 1'b0;
      next_st.zero     = 1'b0;
      next_st.rst_pend = 1'b0;
    end
    else
    begin
      if (in_ok)
      begin
        next_st.raw = crc_fold(st.raw, in_byte, eff_wide);
      end
      // zero test on the value software will read
      if (done)
      begin
        next_st.busy = 1'b0;
        next_st.zero = eff_wide ? (next_st.raw == ccg_pkg::CS_ONES)
                                : (next_st.raw[15:0] == 16'h0000);
      end
      if (hit_ctl & ~st.busy)
      begin
        next_st.wide = I_REQ.wdata[ccg_pkg::CTL_WIDE];
        next_st.src  = new_src;
        if (src_valid)
        begin
          // a selected source marks the module busy
          // fresh selection drops the old zero result
          next_st.busy = 1'b1;
          next_st.zero = 1'b0;
        end
      end
      if (hit_cs & (st.src == ccg_pkg::SRC_OFF))
      begin
        next_st.raw[cs_idx*8 +: 8] = I_REQ.wdata;
      end
    end
    // the reset waits one cycle before it acts
    if (hit_ctl & I_REQ.wdata[ccg_pkg::CTL_RST_HI])
    begin
      next_st.rst_pend = 1'b1;
      next_st.rst_ones = I_REQ.wdata[ccg_pkg::CTL_RST_LO];
    end
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign O_RDATA = st.rdata;
  assign O_BUSY  = st.busy;
  assign O_ZERO  = st.zero;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_CLOCK);
  endclocking
  default disable iff (!I_RST_N);

  chk_io_busy_clear: assert property (
    (st.busy & (st.src == ccg_pkg::SRC_IO) & hit_sts
     & I_REQ.wdata[0] & ~st.rst_pend) |=> !O_BUSY)
    else $error("io completion did not clear busy");

  // checksum ready one clock after a byte
  chk_byte_fold_time: assert property (
    (st.busy & (st.src == ccg_pkg::SRC_IO) & hit_byte & ~st.rst_pend)
    |=> st.raw == crc_fold($past(st.raw), $past(I_REQ.wdata),
                           $past(eff_wide)))
    else $error("byte not folded one clock after write");

  chk_poly_lock: assert property (
    (st.busy & hit_ctl & ~st.rst_pend) |=> $stable(st.wide))
    else $error("polynomial select changed while busy");

  chk_source_lock: assert property (
    (st.busy & hit_ctl & ~st.rst_pend) |=> ##1 (st.src == $past(st.src, 2))
    or st.rst_pend)
    else $error("source changed while busy");

  // soft reset lands on the second edge
  chk_soft_reset: assert property (
    (hit_ctl & I_REQ.wdata[7] & ~I_REQ.wdata[6]) |=> ##1
    (st.raw == ccg_pkg::CS_ZEROS) && !O_BUSY)
    else $error("clear reset did not take effect");

  chk_flash_zero_read: assert property (
    (I_REQ.rd & I_REQ.addr[2] & st.busy
     & (st.src == ccg_pkg::SRC_FLASH)) |=> O_RDATA == 8'h00)
    else $error("flash run exposed checksum");

  chk_flash_wide: assert property (
    (st.busy & (st.src == ccg_pkg::SRC_FLASH) & I_FLASH.valid
     & ~st.rst_pend)
    |=> st.raw == crc_fold($past(st.raw), $past(I_FLASH.data), 1'b1))
    else $error("flash source not folded with wide polynomial");

  // checksum write refused while a run is active
  chk_cs_write_gate: assert property (
    (hit_cs & ~in_ok & ~st.rst_pend & (st.src != ccg_pkg::SRC_OFF))
    |=> $stable(st.raw))
    else $error("checksum written while enabled");

  chk_reserved_idle: assert property (
    (st.src == 4'h3) || st.src[3] |-> !O_BUSY)
    else $error("reserved source raised busy");

  chk_dma_done: assert property (
    (st.busy & src_dma & I_DMA.done[dma_ch]) |=> !O_BUSY)
    else $error("dma completion did not clear busy");

  chk_zero_on_select: assert property (
    (hit_ctl & ~st.busy & src_valid & ~st.rst_pend) |=> !O_ZERO && O_BUSY)
    else $error("zero flag survived a new selection");

endmodule // ccg_top

//--- tb/ccg_far_model.sv
// Purpose: far side model, dma channels and flash feeder
// Assumes: tasks are entered just after a rising edge
// Notes:   released data lines show the inverted last byte
module ccg_far_model
(
  input  wire logic          i_clock,
  output ccg_pkg::ccg_dma_t   o_dma,
  output ccg_pkg::ccg_flash_t o_flash
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 5;
  initial
  begin
    o_dma   = '0;
    o_flash = '0;
  end
  // ========
  // strobes, channel 4 stands for the flash feeder
  // bytes presented
  task automatic put(input int ch, input logic v, input logic [7:0] d);
    if (ch == 4)
    begin
      o_flash.valid = v;
      o_flash.data  = d;
    end
    else
    begin
      o_dma.valid[ch] = v;
      o_dma.data[ch]  = d;
    end
  endtask
  // gap 0 streams a byte every cycle, else idles between bytes
  task automatic send(input int ch, input logic [7:0] q[$], input int gap);
    foreach (q[i])
    begin
      put(ch, 1'b1, q[i]);
      @(posedge i_clock) #DLY;
      if (gap > 0)
      begin
        put(ch, 1'b0, ~q[i]);
        repeat (gap) @(posedge i_clock) #DLY;
      end
    end
    if (gap == 0)
      put(ch, 1'b0, ~q[q.size()-1]);
  endtask
  task automatic finish(input int ch);
    if (ch == 4)
      o_flash.done = 1'b1;
    else
      o_dma.done[ch] = 1'b1;
    @(posedge i_clock) #DLY;
    o_flash.done = 1'b0;
    o_dma.done   = 4'h0;
  endtask
endmodule // ccg_far_model

//--- tb/ccg_top_tb.sv
// Purpose: self-checking bench of the crc generator
// Assumes: reads answer one cycle after the request is driven
// Notes:   expected checksums come from bench-side folding
module ccg_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int DLY = 5;
  logic                clk;
  logic                rst_n;
  ccg_pkg::ccg_req_t   req;
  ccg_pkg::ccg_dma_t   dma;
  ccg_pkg::ccg_flash_t flash;
  logic [7:0]          rdata;
  logic                busy;
  logic                zero;
  int                  fails;
  int                  total_checks;
  logic [7:0]          q[$];
  ccg_top i_ccg_top (.I_CLOCK(clk), .I_RST_N(rst_n), .I_REQ(req),
    .I_DMA(dma), .I_FLASH(flash), .O_RDATA(rdata), .O_BUSY(busy),
    .O_ZERO(zero));
  ccg_far_model i_ccg_far_model (.i_clock(clk), .o_dma(dma),
    .o_flash(flash));
  // ========
  // reference folding
  function automatic logic [15:0] r16(input logic [15:0] r);
    foreach (q[k])
      for (int i = 7; i >= 0; i--)
        r = {r[14:0], 1'b0} ^ ((r[15] ^ q[k][i]) ? 16'h1021 : 16'h0000);
    return r;
  endfunction
  function automatic logic [31:0] r32(input logic [31:0] r);
    foreach (q[k])
      for (int i = 0; i < 8; i++)
        r = {r[30:0], 1'b0} ^ ((r[31] ^ q[k][i]) ? 32'h04C11DB7 : 32'h0);
    return r;
  endfunction
  function automatic logic [31:0] view(input logic [31:0] r);
    for (int i = 0; i < 32; i++)
      view[i] = ~r[31-i];
  endfunction
  // ========
  // port tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick();
    @(posedge clk) #DLY;
  endtask
  task automatic wreg(input logic [2:0] a, input logic [7:0] d);
    req = '{1'b1, 1'b0, a, d};
    tick();
    req = '0;
    tick();
  endtask
  task automatic rreg(input logic [2:0] a, output logic [7:0] v);
    req = '{1'b0, 1'b1, a, 8'h00};
    tick();
    v = rdata;
    req = '0;
    tick();
  endtask
  task automatic rcs(output logic [31:0] v);
    for (int i = 0; i < 4; i++)
      rreg(3'h4 + i[2:0], v[8*i +: 8]);
  endtask
  task automatic feed();
    foreach (q[i])
    begin
      req = '{1'b1, 1'b0, 3'h3, q[i]};
      tick();
    end
    req = '0;
    tick();
  endtask
  // ========
  // scenarios
  task automatic t_regs();
    logic [7:0] v;
    for (int a = 0; a < 8; a++)
    begin
      rreg(a[2:0], v);
      chk(v, 8'h00);
    end
  endtask
  task automatic t_narrow();
    logic [7:0]  v;
    logic [31:0] cs;
    q = '{8'h31, 8'h32, 8'h33};
    wreg(3'h0, 8'hC0);
    wreg(3'h0, 8'h01);
    chk(busy, 1'b1);
    wreg(3'h0, 8'h22);
    wreg(3'h4, 8'h5A);
    rreg(3'h0, v);
    chk(v, 8'h01);
    feed();
    rcs(cs);
    chk(cs, {16'hFFFF, r16(16'hFFFF)});
    wreg(3'h2, 8'h01);
    chk(busy, 1'b0);
  endtask
  task automatic t_wide();
    logic [31:0] cs;
    q = '{8'h31, 8'h32, 8'h33, 8'h34};
    wreg(3'h0, 8'hC0);
    wreg(3'h0, 8'h21);
    feed();
    rcs(cs);
    chk(cs, r32(32'hFFFFFFFF));
    wreg(3'h2, 8'h01);
    rcs(cs);
    chk(cs, view(r32(32'hFFFFFFFF)));
    for (int i = 0; i < 4; i++)
      q.push_back(cs[8*i +: 8]);
    wreg(3'h0, 8'hC0);
    wreg(3'h0, 8'h21);
    feed();
    wreg(3'h2, 8'h01);
    rcs(cs);
    chk(cs, 32'h2144DF1C);
    chk(zero, 1'b0);
    // complemented checksum appended: raw register ends at zero
    for (int i = 4; i < 8; i++)
      q[i] = ~q[i];
    wreg(3'h0, 8'hC0);
    wreg(3'h0, 8'h21);
    feed();
    rcs(cs);
    chk(cs, 32'h00000000);
    wreg(3'h2, 8'h01);
    rcs(cs);
    chk(cs, 32'hFFFFFFFF);
  endtask
  task automatic t_zero();
    logic [7:0] v;
    q = '{8'h00};
    wreg(3'h0, 8'h80);
    wreg(3'h0, 8'h01);
    feed();
    wreg(3'h2, 8'h01);
    rreg(3'h2, v);
    chk(v, 8'h02);
    wreg(3'h0, 8'h01);
    chk({zero, busy}, 2'b01);
    wreg(3'h2, 8'h01);
  endtask
  task automatic t_dma();
    logic [31:0] cs;
    q = '{8'hA5, 8'h3C};
    for (int ch = 0; ch < 4; ch++)
    begin
      wreg(3'h0, 8'h80);
      wreg(3'h0, {4'h0, ccg_pkg::SRC_DMA, ch[1:0]});
      i_ccg_far_model.send((ch + 1) % 4, q, 1);
      i_ccg_far_model.send(ch, q, ch % 2);
      chk(busy, 1'b1);
      i_ccg_far_model.finish(ch);
      chk(busy, 1'b0);
      rcs(cs);
      chk(cs, {16'h0000, r16(16'h0000)});
    end
  endtask
  task automatic t_flash();
    logic [31:0] cs;
    q = '{8'h10, 8'hEF, 8'h42};
    wreg(3'h0, 8'hC0);
    wreg(3'h0, 8'h02);
    i_ccg_far_model.send(4, q, 0);
    rcs(cs);
    chk(cs, 32'h0);
    i_ccg_far_model.finish(4);
    chk(busy, 1'b0);
    rcs(cs);
    chk(cs, view(r32(32'hFFFFFFFF)));
  endtask
  task automatic t_soft();
    logic [7:0]  v;
    logic [31:0] cs;
    wreg(3'h0, 8'h01);
    req = '{1'b1, 1'b0, 3'h0, 8'hC0};
    tick();
    req = '0;
    chk(busy, 1'b1);
    tick();
    chk(busy, 1'b0);
    rreg(3'h0, v);
    chk(v, 8'h00);
    wreg(3'h0, 8'h40);
    rcs(cs);
    chk(cs, 32'hFFFFFFFF);
  endtask
  task automatic t_resv();
    logic [7:0] v;
    wreg(3'h0, 8'h80);
    wreg(3'h4, 8'h5A);
    wreg(3'h0, 8'h03);
    chk(busy, 1'b0);
    wreg(3'h3, 8'h77);
    wreg(3'h0, 8'h08);
    chk(busy, 1'b0);
    rreg(3'h4, v);
    chk(v, 8'h5A);
  endtask
  // pin reset in the middle of a run drops busy and the checksum
  task automatic t_hard();
    logic [31:0] cs;
    wreg(3'h0, 8'h01);
    chk(busy, 1'b1);
    rst_n = 1'b0;
    tick();
    tick();
    rst_n = 1'b1;
    chk(busy, 1'b0);
    rcs(cs);
    chk(cs, 32'h00000000);
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // ========
  // clock, sequence and watchdog
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    fails = 0;
    total_checks = 0;
    rst_n = 1'b0;
    req = '0;
    repeat (8) @(posedge clk);
    #DLY;
    rst_n = 1'b1;
    t_regs();
    t_narrow();
    t_wide();
    t_zero();
    t_dma();
    t_flash();
    t_soft();
    t_resv();
    t_hard();
    end_of_test();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    end_of_test();
  end
endmodule // ccg_top_tb
